/* hdl/ethc_irq_status.sv */
// ethc_irq_status: interrupt status, mask, ack and discard control
//
// Chosen here: the APB slave port and the placing of the registers.
module ethc_irq_status (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rstn_i,
	// apb slave
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [7:0]                  paddr_i,
	input  wire logic [31:0]                 pwdata_i,
	input  wire logic [3:0]                  pstrb_i,
	output logic [31:0]                      prdata_o,
	output logic                             pready_o,
	output logic                             pslverr_o,
	// phy and protocol handler events
	input  wire logic [ethc_pkg::ETHC_PHY_BITS-1:0] phy_status_i,
	input  wire logic                        link_event_i,
	input  wire logic                        counter_wrap_i,
	input  wire logic                        tx_fault_i,
	input  wire ethc_pkg::ethc_fault_t       tx_fault_cause_i,
	input  wire logic                        tx_done_i,
	// queue and buffer manager states
	input  wire logic                        alloc_failed_i,
	input  wire logic                        tx_compl_void_i,
	input  wire logic                        rx_queue_void_i,
	input  wire logic                        tx_queue_empty_i,
	// receiver events
	input  wire logic                        rx_alloc_overrun_i,
	input  wire logic                        rx_too_long_i,
	input  wire logic                        rx_frame_active_i,
	input  wire logic                        rx_frame_end_i,
	// outputs to host and datapath
	output logic                             irq_o,
	output logic                             tx_enable_o,
	output logic                             tx_compl_pop_o,
	output logic                             rx_drop_o
);
	import ethc_pkg::*;

	ethc_apb_req_t req;
	logic        acc;
	logic        wr_acc;
	logic        rd_acc;
	logic        map_hit;
	logic        ack_w;
	logic [7:0]  ack_b;
	logic [7:0]  stat;
	logic [7:0]  mask_q;
	logic [3:0]  ctrl_q;
	logic        ctrl_w;
	logic        phy_flag_q;
	logic        phy_chg;
	logic        phy_rd;
	logic [ETHC_PHY_BITS-1:0] phy_held;
	logic        link_cause_q;
	logic        cnt_cause_q;
	logic        txf_cause_q;
	logic        tx_success_q;
	ethc_fault_t cause_q;
	logic        rx_abort_q;
	logic        rx_abort_set;
	logic        drain_q;
	logic        empty_prev_q;
	logic        disc_q;
	logic        disc_drop;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic        irq_q;

	assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
		addr: paddr_i, wdata: pwdata_i, strb: pstrb_i};

	// zero-wait slave; read data captured in setup, so it comes from flops
	assign acc     = req.sel && req.enable;
	assign wr_acc  = acc && req.write && map_hit;
	assign rd_acc  = acc && !req.write && map_hit;
	assign map_hit = (req.addr == ETHC_OFS_IRQ)  || (req.addr == ETHC_OFS_RCV)
		|| (req.addr == ETHC_OFS_CTRL) || (req.addr == ETHC_OFS_EPHS)
		|| (req.addr == ETHC_OFS_PHY)  || (req.addr == ETHC_OFS_CNT);
	assign pready_o  = 1'b1;
	assign pslverr_o = acc && !map_hit;
	assign prdata_o  = rdata_q;

	// ack is the low byte lane only; reserved bits ignored
	assign ack_w = wr_acc && (req.addr == ETHC_OFS_IRQ) && req.strb[0];
	assign ack_b = ack_w ? req.wdata[7:0] : 8'h00;
	assign ctrl_w = wr_acc && (req.addr == ETHC_OFS_CTRL) && req.strb[0];
	assign phy_rd = rd_acc && (req.addr == ETHC_OFS_PHY);

	// status view
	always_comb begin
		stat = 8'h00;
		stat[ETHC_B_RXPEND]  = !rx_queue_void_i;
		stat[ETHC_B_TXCOMP]  = !tx_compl_void_i;
		stat[ETHC_B_TXDRAIN] = drain_q;
		stat[ETHC_B_ALLOC]   = !alloc_failed_i;
		stat[ETHC_B_RXABORT] = rx_abort_q;
		stat[ETHC_B_EPH]     = link_cause_q || cnt_cause_q || txf_cause_q;
		stat[ETHC_B_PHY]     = phy_flag_q;
	end

	// mask register, byte lane 1 (bits 15:8) of the irq word
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mask_q <= ETHC_MASK_RST;
		end else if (wr_acc && (req.addr == ETHC_OFS_IRQ) && req.strb[1]) begin
			mask_q <= req.wdata[15:8];
		end
	end

	// interrupt line, registered
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat & mask_q);
		end
	end
	assign irq_o = irq_q;

	// phy change latches
	ethc_phy_latch u_phy (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.live_i (phy_status_i),
		.rd_i   (phy_rd),
		.held_o (phy_held),
		.chg_o  (phy_chg)
	);

	// phy flag: set wins over ack
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phy_flag_q <= 1'b0;
		end else if (phy_chg) begin
			phy_flag_q <= 1'b1;
		end else if (ack_b[ETHC_B_PHY]) begin
			phy_flag_q <= 1'b0;
		end
	end

	// control register: enables and tx enable
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_q <= ETHC_CTRL_RST;
		end else begin
			if (ctrl_w) begin
				ctrl_q <= req.wdata[3:0];
			end
			// a fault beats a same-cycle software enable
			if (tx_fault_i) begin
				ctrl_q[ETHC_C_TXEN] <= 1'b0;
			end
		end
	end
	assign tx_enable_o = ctrl_q[ETHC_C_TXEN];

	// link cause: cleared by dropping its enable
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link_cause_q <= 1'b0;
		end else if (link_event_i && ctrl_q[ETHC_C_LE]) begin
			link_cause_q <= 1'b1;
		end else if (ctrl_w && !req.wdata[ETHC_C_LE]) begin
			link_cause_q <= 1'b0;
		end
	end

	// counter cause: cleared by reading the counter register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_cause_q <= 1'b0;
		end else if (counter_wrap_i && ctrl_q[ETHC_C_CR]) begin
			cnt_cause_q <= 1'b1;
		end else if (rd_acc && (req.addr == ETHC_OFS_CNT)) begin
			cnt_cause_q <= 1'b0;
		end
	end

	// tx fault cause: cleared by re-enabling tx or dropping its enable
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			txf_cause_q <= 1'b0;
		end else if (tx_fault_i && ctrl_q[ETHC_C_TE]) begin
			txf_cause_q <= 1'b1;
		end else if (ctrl_w && (req.wdata[ETHC_C_TXEN] || !req.wdata[ETHC_C_TE])) begin
			txf_cause_q <= 1'b0;
		end
	end

	// fault record and success flag
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cause_q      <= '0;
			tx_success_q <= 1'b0;
		end else if (tx_fault_i) begin
			cause_q      <= tx_fault_cause_i;
			tx_success_q <= 1'b0;
		end else if (tx_done_i) begin
			tx_success_q <= 1'b1;
		end
	end

	// discard request: self clears at frame end or when idle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			disc_q <= 1'b0;
		end else if (wr_acc && (req.addr == ETHC_OFS_RCV) && req.strb[0]
			&& req.wdata[ETHC_R_DISC]) begin
			disc_q <= 1'b1;
		end else if (rx_frame_end_i || !rx_frame_active_i) begin
			disc_q <= 1'b0;
		end
	end
	// a discard after the frame has ended leaves that frame alone
	assign disc_drop = disc_q && rx_frame_active_i && rx_frame_end_i;
	assign rx_drop_o = disc_drop;

	// rx abort: set wins over ack
	assign rx_abort_set = rx_alloc_overrun_i || rx_too_long_i || disc_drop;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_abort_q <= 1'b0;
		end else if (rx_abort_set) begin
			rx_abort_q <= 1'b1;
		end else if (ack_b[ETHC_B_RXABORT]) begin
			rx_abort_q <= 1'b0;
		end
	end

	// tx drained: latch rising edge of queue empty
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			empty_prev_q <= 1'b1;
			drain_q      <= 1'b0;
		end else begin
			empty_prev_q <= tx_queue_empty_i;
			if (tx_queue_empty_i && !empty_prev_q) begin
				drain_q <= 1'b1;
			end else if (ack_b[ETHC_B_TXDRAIN]) begin
				drain_q <= 1'b0;
			end
		end
	end

	// completion ack pops the head packet number
	assign tx_compl_pop_o = ack_b[ETHC_B_TXCOMP] && !tx_compl_void_i;

	// read mux, sampled in setup phase
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (req.addr)
			ETHC_OFS_IRQ:  rdata_d[15:0] = {mask_q, stat};
			ETHC_OFS_RCV:  rdata_d[ETHC_R_DISC] = disc_q;
			ETHC_OFS_CTRL: rdata_d[3:0] = ctrl_q;
			ETHC_OFS_EPHS: rdata_d[10:0] = {txf_cause_q, cnt_cause_q, link_cause_q,
				3'h0, cause_q, tx_success_q};
			ETHC_OFS_PHY:  rdata_d[ETHC_PHY_BITS-1:0] = phy_held;
			ETHC_OFS_CNT:  rdata_d[0] = cnt_cause_q;
			default:       rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (req.sel && !req.enable) begin
			rdata_q <= rdata_d;
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_fault;
		tx_fault_i && ctrl_q[ETHC_C_TE];
	endsequence

	// a discard still armed when its frame ends
	sequence s_drop;
		disc_q && rx_frame_active_i && rx_frame_end_i;
	endsequence

	chk_irq_out_gate: assert property (
		|(stat & mask_q) |=> irq_o)
		else $error("masked status did not raise irq");
	chk_irq_out_quiet: assert property (
		!(|(stat & mask_q)) |=> !irq_o)
		else $error("irq raised without masked status");
	chk_phy_flag_set: assert property (
		phy_chg |=> phy_flag_q)
		else $error("phy change did not set flag");
	chk_phy_flag_hold: assert property (
		phy_flag_q && !(ack_w && req.wdata[ETHC_B_PHY]) |=> phy_flag_q)
		else $error("phy flag cleared without ack");
	chk_phy_ack_clear: assert property (
		ack_b[ETHC_B_PHY] && !phy_chg |=> !phy_flag_q)
		else $error("phy flag kept after ack");
	chk_eph_tx_fault: assert property (
		s_fault |=> stat[ETHC_B_EPH] && !tx_enable_o && !tx_success_q)
		else $error("tx fault not merged or enable kept");
	chk_link_gated: assert property (
		link_event_i && !ctrl_q[ETHC_C_LE] && !link_cause_q |=> !link_cause_q)
		else $error("disabled link event set exception");
	chk_fault_cause_rec: assert property (
		tx_fault_i |=> cause_q == $past(tx_fault_cause_i))
		else $error("fault cause not recorded");
	chk_link_clear: assert property (
		ctrl_w && !req.wdata[ETHC_C_LE] && !link_event_i |=> !link_cause_q)
		else $error("link cause kept after enable cleared");
	chk_cnt_clear: assert property (
		rd_acc && (req.addr == ETHC_OFS_CNT) && !counter_wrap_i |=> !cnt_cause_q)
		else $error("counter cause kept after read");
	chk_txf_clear: assert property (
		ctrl_w && req.wdata[ETHC_C_TXEN] && !tx_fault_i |=> !txf_cause_q && tx_enable_o)
		else $error("tx fault cause kept after enable set");
	chk_rx_abort_hold: assert property (
		rx_abort_q && !(ack_w && req.wdata[ETHC_B_RXABORT]) |=> rx_abort_q)
		else $error("rx abort lost without ack");
	chk_rx_abort_ack: assert property (
		ack_b[ETHC_B_RXABORT] && !rx_abort_set |=> !rx_abort_q)
		else $error("rx abort kept after ack");
	chk_rx_abort_set: assert property (
		rx_abort_set |=> rx_abort_q)
		else $error("rx abort not set");
	chk_alloc_inverse: assert property (
		req.sel && !req.enable && (req.addr == ETHC_OFS_IRQ)
		|=> prdata_o[ETHC_B_ALLOC] != $past(alloc_failed_i))
		else $error("alloc flag not inverse of failed");
	chk_drain_latch: assert property (
		$rose(tx_queue_empty_i) |=> drain_q ##1 (drain_q || $past(ack_w)))
		else $error("drained flag not latched");
	chk_drain_hold: assert property (
		drain_q && !ack_b[ETHC_B_TXDRAIN] |=> drain_q)
		else $error("drained flag lost without ack");
	chk_drain_ack: assert property (
		ack_b[ETHC_B_TXDRAIN] && !tx_queue_empty_i |=> !drain_q)
		else $error("drained flag kept after ack");
	chk_mask_write: assert property (
		wr_acc && (req.addr == ETHC_OFS_IRQ) && req.strb[1]
		|=> mask_q == $past(pwdata_i[15:8]))
		else $error("mask byte not written");
	chk_pop_on_ack: assert property (
		ack_w && req.wdata[ETHC_B_TXCOMP] && !tx_compl_void_i |-> tx_compl_pop_o)
		else $error("completion ack did not pop");
	chk_pop_quiet: assert property (
		!ack_w |-> !tx_compl_pop_o)
		else $error("pop without ack write");
	chk_ack_no_set: assert property (
		ack_w && !rx_abort_set && !rx_abort_q |=> !rx_abort_q)
		else $error("ack write set a status bit");
	chk_discard_clear: assert property (
		disc_q && !rx_frame_active_i |=> !disc_q)
		else $error("discard did not self clear");
	chk_discard_abort: assert property (
		s_drop |-> rx_drop_o ##1 rx_abort_q)
		else $error("discarded frame not dropped or flagged");
endmodule // ethc_irq_status

/* hdl/ethc_phy_latch.sv */
// ethc_phy_latch: transition-latched phy status bits
module ethc_phy_latch (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rstn_i,
	// live bits and read strobe
	input  wire logic [ethc_pkg::ETHC_PHY_BITS-1:0] live_i,
	input  wire logic                         rd_i,
	// latched view and change pulse
	output logic [ethc_pkg::ETHC_PHY_BITS-1:0] held_o,
	output logic                              chg_o
);
	import ethc_pkg::*;

	logic [ETHC_PHY_BITS-1:0] val_q;
	logic [ETHC_PHY_BITS-1:0] lock_q;
	logic [ETHC_PHY_BITS-1:0] hit;
	logic                     arm_q;

	// first cycle after reset loads the live bits, so a pin already set gives no false change
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			arm_q <= 1'b0;
		end else begin
			arm_q <= 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < ETHC_PHY_BITS; g++) begin : g_bit
			// a held bit ignores later edges until read
			assign hit[g] = arm_q && !lock_q[g] && (live_i[g] != val_q[g]);
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					val_q[g]  <= 1'b0;
					lock_q[g] <= 1'b0;
				end else if (rd_i || !arm_q) begin
					val_q[g]  <= live_i[g];
					lock_q[g] <= 1'b0;
				end else if (hit[g]) begin
					val_q[g]  <= live_i[g];
					lock_q[g] <= 1'b1;
				end
			end
		end
	endgenerate

	assign held_o = val_q;
	assign chg_o  = |hit;
endmodule // ethc_phy_latch

/* inc/ethc_pkg.sv */
// ethc_pkg: constants and types of the interrupt status block
package ethc_pkg;
	// register byte offsets
	localparam logic [7:0] ETHC_OFS_IRQ  = 8'h00;
	localparam logic [7:0] ETHC_OFS_RCV  = 8'h04;
	localparam logic [7:0] ETHC_OFS_CTRL = 8'h08;
	localparam logic [7:0] ETHC_OFS_EPHS = 8'h0C;
	localparam logic [7:0] ETHC_OFS_PHY  = 8'h10;
	localparam logic [7:0] ETHC_OFS_CNT  = 8'h14;
	// status bit positions (low byte of irq register)
	localparam int ETHC_B_RXPEND  = 0;
	localparam int ETHC_B_TXCOMP  = 1;
	localparam int ETHC_B_TXDRAIN = 2;
	localparam int ETHC_B_ALLOC   = 3;
	localparam int ETHC_B_RXABORT = 4;
	localparam int ETHC_B_EPH     = 5;
	localparam int ETHC_B_PHY     = 7;
	// control register bit positions
	localparam int ETHC_C_LE   = 0;
	localparam int ETHC_C_CR   = 1;
	localparam int ETHC_C_TE   = 2;
	localparam int ETHC_C_TXEN = 3;
	// receive control discard bit
	localparam int ETHC_R_DISC = 7;
	// reset values, phy status width and collision limit
	localparam logic [7:0] ETHC_MASK_RST = 8'h00;
	localparam logic [3:0] ETHC_CTRL_RST = 4'h0;
	localparam int ETHC_PHY_BITS = 9;
	localparam int ETHC_COLL_MAX = 16;
	// fault cause carrier; excess means ETHC_COLL_MAX collisions
	typedef struct packed {
		logic sqe_fault;
		logic carrier_drop;
		logic late_collision_fault;
		logic excess_collision_fault;
	} ethc_fault_t;
	// apb request carrier
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [3:0]  strb;
	} ethc_apb_req_t;
endpackage

/* testbench/ethc_host_model.sv */
// ethc_host_model: host processor apb master and interrupt input
module ethc_host_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// apb master
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [7:0]       paddr_o,
	output logic [31:0]      pwdata_o,
	output logic [3:0]       pstrb_o,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i,
	// interrupt line
	input  wire logic        irq_i
);
	timeunit 1ns;
	timeprecision 1ps;
	import ethc_pkg::*;
	initial begin
		{psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;
	end
	// request holds until pready is seen high; no wait count is assumed
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q, output logic e);
		@(posedge clk_i);
		psel_o    <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o  <= w;
		paddr_o   <= a;
		pwdata_o  <= (a == ETHC_OFS_IRQ) ? (d & 32'hFFFF_FFBF) : d;
		pstrb_o   <= w ? s : 4'h0;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do @(posedge clk_i); while (pready_i !== 1'b1);
		q = prdata_i;
		e = pslverr_i;
		psel_o    <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule // ethc_host_model

/* testbench/tb_ethc_irq_status.sv */
// tb_ethc_irq_status: self-checking bench of the interrupt status block
module tb_ethc_irq_status;
	timeunit 1ns;
	timeprecision 1ps;
	import ethc_pkg::*;
	typedef struct packed {
		logic [2:0] lv;
		logic [7:0] st;
	} ethc_row_t;
	logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rerr;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, rdat;
	logic [3:0]  pstrb_i;
	logic [8:0]  phy_status_i;
	logic [6:0]  ev;
	ethc_fault_t tx_fault_cause_i;
	logic        alloc_failed_i, tx_compl_void_i, rx_queue_void_i, tx_queue_empty_i;
	logic        rx_frame_active_i, irq_o, tx_enable_o, tx_compl_pop_o, rx_drop_o;
	int          errors, cmp_count, pops, drops, cyc;
	ethc_row_t   rows [5] = '{'{3'b111, 8'h00}, '{3'b011, 8'h01}, '{3'b101, 8'h02},
		'{3'b110, 8'h08}, '{3'b000, 8'h0B}};
	ethc_irq_status ethc_irq_status_i (
		.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
		.prdata_o, .pready_o, .pslverr_o, .phy_status_i, .link_event_i(ev[0]),
		.counter_wrap_i(ev[1]), .tx_fault_i(ev[2]), .tx_fault_cause_i, .tx_done_i(ev[3]),
		.alloc_failed_i, .tx_compl_void_i, .rx_queue_void_i, .tx_queue_empty_i,
		.rx_alloc_overrun_i(ev[4]), .rx_too_long_i(ev[5]), .rx_frame_active_i,
		.rx_frame_end_i(ev[6]), .irq_o, .tx_enable_o, .tx_compl_pop_o, .rx_drop_o
	);
	ethc_host_model ethc_host_model_i (
		.clk_i, .rstn_i, .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
		.paddr_o(paddr_i), .pwdata_o(pwdata_i), .pstrb_o(pstrb_i), .prdata_i(prdata_o),
		.pready_i(pready_o), .pslverr_i(pslverr_o), .irq_i(irq_o)
	);
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// pulse counters sampled on the edge, so comb pulses are never missed
	always @(posedge clk_i) begin
		cyc++;
		if (tx_compl_pop_o === 1'b1) pops++;
		if (rx_drop_o === 1'b1) drops++;
		if (cyc == 5000) begin
			errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		ethc_host_model_i.xfer(1'b1, a, d, s, rdat, rerr);
	endtask
	task automatic rd(input logic [7:0] a);
		ethc_host_model_i.xfer(1'b0, a, 32'h0, 4'h0, rdat, rerr);
	endtask
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask
	// event pulse, then one cycle more for the registered irq
	task automatic pulse(input int b);
		@(posedge clk_i);
		ev[b] <= 1'b1;
		@(posedge clk_i);
		ev[b] <= 1'b0;
		tick();
	endtask
	initial begin
		{ev, tx_fault_cause_i, phy_status_i, rx_frame_active_i} = '0;
		{alloc_failed_i, tx_compl_void_i, rx_queue_void_i, tx_queue_empty_i} = '1;
		rstn_i = 1'b0;
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(ETHC_OFS_IRQ);
		chk(rdat, 32'h0, "irq reg reset");
		rd(ETHC_OFS_CTRL);
		chk({rdat[3:0], irq_o, tx_enable_o}, 6'h0, "ctrl reset");
		$display("test reset done");
		foreach (rows[i]) begin
			@(posedge clk_i);
			{rx_queue_void_i, tx_compl_void_i, alloc_failed_i} <= rows[i].lv;
			rd(ETHC_OFS_IRQ);
			chk(rdat[7:0], rows[i].st, "level flags");
		end
		wr(ETHC_OFS_IRQ, 32'h0000_0100, 4'h3);
		tick();
		chk(irq_o, 1'b1, "word mask irq");
		@(posedge clk_i);
		{rx_queue_void_i, tx_compl_void_i, alloc_failed_i} <= 3'b111;
		wr(ETHC_OFS_IRQ, 32'h0000_1000, 4'h2);
		rd(ETHC_OFS_IRQ);
		chk({rdat[15:0], irq_o}, 17'h2000, "byte mask");
		$display("test levels and mask done");
		for (int b = 4; b < 6; b++) begin
			pulse(b);
			chk(irq_o, 1'b1, "abort irq");
			wr(ETHC_OFS_IRQ, 32'h0000_00EF, 4'h1);
			rd(ETHC_OFS_IRQ);
			chk(rdat[15:0], 16'h1010, "abort held");
			wr(ETHC_OFS_IRQ, 32'h0000_0010, 4'h1);
			rd(ETHC_OFS_IRQ);
			chk({rdat[7:0], irq_o}, 9'h0, "abort acked");
		end
		@(posedge clk_i);
		rx_frame_active_i <= 1'b1;
		wr(ETHC_OFS_RCV, 32'h80, 4'hF);
		pulse(6);
		chk(drops, 1, "discard drop");
		chk(irq_o, 1'b1, "discard abort");
		wr(ETHC_OFS_IRQ, 32'h0000_0010, 4'h1);
		@(posedge clk_i);
		rx_frame_active_i <= 1'b0;
		wr(ETHC_OFS_RCV, 32'h80, 4'hF);
		rd(ETHC_OFS_RCV);
		chk(rdat[7], 1'b0, "discard self clear");
		@(posedge clk_i);
		rx_frame_active_i <= 1'b1;
		pulse(6);
		rd(ETHC_OFS_IRQ);
		chk({drops[7:0], rdat[7:0]}, 16'h0100, "late discard");
		$display("test abort done");
		@(posedge clk_i);
		phy_status_i <= 9'h008;
		wr(ETHC_OFS_IRQ, 32'h0000_8000, 4'h2);
		rd(ETHC_OFS_IRQ);
		chk({rdat[7:0], irq_o}, 9'h101, "phy flag");
		rd(ETHC_OFS_PHY);
		chk(rdat[8:0], 9'h008, "phy held");
		@(posedge clk_i);
		phy_status_i <= 9'h108;
		@(posedge clk_i);
		phy_status_i <= 9'h008; // bit falls back before the read
		rd(ETHC_OFS_PHY);
		chk(rdat[8:0], 9'h108, "phy relatch");
		rd(ETHC_OFS_PHY);
		chk(rdat[8:0], 9'h008, "phy refresh");
		wr(ETHC_OFS_IRQ, 32'h0000_0080, 4'h1);
		rd(ETHC_OFS_IRQ);
		chk({rdat[7:0], irq_o}, 9'h0, "phy acked");
		$display("test phy done");
		@(posedge clk_i);
		tx_queue_empty_i <= 1'b0; // a frame is queued
		wr(ETHC_OFS_IRQ, 32'h0000_0004, 4'h1);
		wr(ETHC_OFS_IRQ, 32'h0000_0400, 4'h2);
		@(posedge clk_i);
		tx_queue_empty_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk(irq_o, 1'b1, "drained irq");
		wr(ETHC_OFS_IRQ, 32'h0000_0004, 4'h1);
		rd(ETHC_OFS_IRQ);
		chk({rdat[7:0], irq_o}, 9'h0, "drained acked");
		$display("test drained done");
		wr(ETHC_OFS_CTRL, 32'h0, 4'hF);
		pulse(0);
		rd(ETHC_OFS_IRQ);
		chk(rdat[5], 1'b0, "link gated");
		wr(ETHC_OFS_CTRL, 32'h0F, 4'hF);
		tick();
		chk(tx_enable_o, 1'b1, "tx enable set");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			tx_fault_cause_i <= ethc_fault_t'(4'h8 >> i);
			pulse(2);
			chk(tx_enable_o, 1'b0, "fault clears enable");
			rd(ETHC_OFS_EPHS);
			chk(rdat[10:0], 11'h400 | (11'h10 >> i), "fault cause");
			rd(ETHC_OFS_IRQ);
			chk(rdat[5], 1'b1, "fault exception");
			wr(ETHC_OFS_CTRL, (i == 3) ? 32'h03 : 32'h0F, 4'hF);
			rd(ETHC_OFS_IRQ);
			chk(rdat[5], 1'b0, "fault cleared");
		end
		pulse(1);
		rd(ETHC_OFS_IRQ);
		chk(rdat[5], 1'b1, "counter exception");
		rd(ETHC_OFS_CNT);
		chk(rdat[0], 1'b1, "counter cause");
		rd(ETHC_OFS_IRQ);
		chk(rdat[5], 1'b0, "counter cleared");
		pulse(0);
		rd(ETHC_OFS_IRQ);
		chk(rdat[5], 1'b1, "link exception");
		wr(ETHC_OFS_CTRL, 32'h02, 4'hF);
		rd(ETHC_OFS_IRQ);
		chk(rdat[5], 1'b0, "link cleared");
		$display("test exception done");
		@(posedge clk_i);
		tx_compl_void_i <= 1'b0;
		pulse(3);
		wr(ETHC_OFS_IRQ, 32'h0000_0002, 4'h1);
		rd(ETHC_OFS_IRQ);
		chk({pops[7:0], rdat[1]}, 9'h003, "pop on ack");
		@(posedge clk_i);
		tx_compl_void_i <= 1'b1;
		wr(ETHC_OFS_IRQ, 32'h0000_0002, 4'h1);
		rd(ETHC_OFS_IRQ);
		chk({pops[7:0], rdat[1]}, 9'h002, "no pop when void");
		rd(8'h20);
		chk(rerr, 1'b1, "unmapped error");
		chk(rdat, 32'h0, "unmapped read");
		$display("test pop and unmapped done");
		wr(ETHC_OFS_IRQ, 32'h0000_FF00, 4'h2);
		wr(ETHC_OFS_CTRL, 32'h08, 4'hF);
		@(posedge clk_i);
		alloc_failed_i <= 1'b0;
		tick();
		chk({irq_o, tx_enable_o}, 2'b11, "before reset");
		@(posedge clk_i);
		rstn_i <= 1'b0;
		tick();
		chk({irq_o, tx_enable_o}, 2'b00, "reset outputs");
		@(posedge clk_i);
		rstn_i <= 1'b1;
		rd(ETHC_OFS_IRQ);
		chk({rdat[15:0], irq_o}, 17'h0_0010, "mask after reset");
		$display("test mid reset done");
		complete_run();
	end
endmodule // tb_ethc_irq_status
